/* design/pulse_modulator.sv */
// Single-channel pulse width modulator with an AXI4-Lite register slave.
// Functional notes
// - Output modulates only while run bit set
// - Setting run bit starts a cycle immediately
// - Duty zero gives 0%, FF/FF gives 255/256
// - Polarity one with duty zero gives 100%
// - Polarity selects active level; idle output high
// - Duty write shadows polarity, applied at cycle end
// - Duty and period reload at start or wrap
// - Wrap sets cycle flag; write one clears
// - Four-bit rate code selects sixteen dividers
// - Rate changes act at once; avoid mid-cycle
// - Duty above period holds passive state
// - Frame lasts period plus one ticks
// - Eight-bit duty and period registers
// - All registers accessible any time
// - Keeps modulating in wait state
// - Clock halt in stop freezes waveform
// - Reset clears run, rate, polarity, duty
// Assumes a single 125 MHz clock; the oscillator is aclk and stop halts it.
`timescale 1ns/1ps
`include "pulse_modulator_regs.svh"

module pulse_modulator
   import pulse_modulator_pkg::*;
(
   input  wire logic        aclk,           // System clock
   input  wire logic        aresetn,        // Synchronous reset, active low
   input  wire logic [31:0] s_axi_awaddr,   // Write address
   input  wire logic        s_axi_awvalid,  // Write address valid
   output logic             s_axi_awready,  // Write address ready
   input  wire logic [31:0] s_axi_wdata,    // Write data
   input  wire logic [3:0]  s_axi_wstrb,    // Write strobes
   input  wire logic        s_axi_wvalid,   // Write data valid
   output logic             s_axi_wready,   // Write data ready
   output logic [1:0]       s_axi_bresp,    // Write response
   output logic             s_axi_bvalid,   // Write response valid
   input  wire logic        s_axi_bready,   // Write response ready
   input  wire logic [31:0] s_axi_araddr,   // Read address
   input  wire logic        s_axi_arvalid,  // Read address valid
   output logic             s_axi_arready,  // Read address ready
   output logic [31:0]      s_axi_rdata,    // Read data
   output logic [1:0]       s_axi_rresp,    // Read response
   output logic             s_axi_rvalid,   // Read data valid
   input  wire logic        s_axi_rready,   // Read data ready
   output logic             pwm_out,        // Modulated output pin
   output logic             irq             // Level interrupt
);

   // -----------------------------------------------------------------------------
   // Register state
   // -----------------------------------------------------------------------------
   logic          run_reg;            // Run bit
   logic          polarity_reg;       // Programmed polarity
   logic          cycle_flag_reg;     // Frame-end flag
   rate_code_type rate_reg;           // Rate code
   byte_type      duty_reg;           // Pending duty value
   byte_type      period_reg;         // Pending period value
   logic          shadow_pol_reg;     // Polarity copied on duty write
   logic          irq_mask_reg;       // Interrupt mask
   logic          irq_status_reg;     // Sticky wrap event

   // Active copies used by the generator
   byte_type      act_duty_reg;       // Duty in use
   byte_type      act_period_reg;     // Period in use
   logic          act_pol_reg;        // Polarity in use
   byte_type      count_reg;          // Modulator clock counter
   logic          out_reg;            // Registered output

   // -----------------------------------------------------------------------------
   // AXI4-Lite write channel
   // -----------------------------------------------------------------------------
   logic       aw_held_reg;   // Address captured
   logic [9:0] aw_addr_reg;   // Captured byte address
   logic       w_held_reg;    // Data captured
   logic [7:0] w_data_reg;    // Captured low byte
   logic       w_lane0_reg;   // Low byte lane enabled
   logic       bvalid_reg;    // Response pending
   logic [1:0] bresp_reg;     // Response code

   // Handshakes and write decode
   wire        aw_take   = s_axi_awvalid && s_axi_awready;
   wire        w_take    = s_axi_wvalid && s_axi_wready;
   wire        wr_fire   = aw_held_reg && w_held_reg && !bvalid_reg;
   wire        wr_ctrl   = wr_fire && (aw_addr_reg == `CONTROL_ADDR);
   wire        wr_duty   = wr_fire && (aw_addr_reg == `DUTY_ADDR);
   wire        wr_period = wr_fire && (aw_addr_reg == `PERIOD_ADDR);
   wire        wr_stat   = wr_fire && (aw_addr_reg == `IRQ_STATUS_ADDR);
   wire        wr_mask   = wr_fire && (aw_addr_reg == `IRQ_MASK_ADDR);
   wire        wr_hit    = wr_ctrl || wr_duty || wr_period || wr_stat || wr_mask;
   wire        wr_byte   = wr_fire && w_lane0_reg;

   // Closed while held or answering
   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready  = !w_held_reg && !bvalid_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;

   // Capture address and data in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // Nothing captured
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 10'h000;
         w_held_reg  <= 1'b0;
         w_data_reg  <= 8'h00;
         w_lane0_reg <= 1'b0;
      end else begin
         // Address phase
         if (aw_take) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= {s_axi_awaddr[9:2], 2'b00};
         end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
         end

         // Data phase, low byte lane
         if (w_take) begin
            w_held_reg  <= 1'b1;
            w_data_reg  <= s_axi_wdata[7:0];
            w_lane0_reg <= s_axi_wstrb[0];
         end else if (wr_fire) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   // Write response; unmapped addresses answer with an error
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // No answer pending
         bvalid_reg <= 1'b0;
         bresp_reg  <= `RESP_OKAY;
      end else if (wr_fire) begin
         // Write performed
         bvalid_reg <= 1'b1;
         bresp_reg  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
         // Answer taken
         bvalid_reg <= 1'b0;
      end
   end

   // -----------------------------------------------------------------------------
   // AXI4-Lite read channel
   // -----------------------------------------------------------------------------
   logic        rvalid_reg;  // Read data pending
   logic [31:0] rdata_reg;   // Read data
   logic [1:0]  rresp_reg;   // Read response
   logic [9:0]  rd_addr;     // Read word address
   logic [7:0]  rd_value;    // Selected register
   logic        rd_hit;      // Address mapped

   // Word address of the read
   assign rd_addr = {s_axi_araddr[9:2], 2'b00};
   assign rd_hit  = (rd_addr == `CONTROL_ADDR) || (rd_addr == `DUTY_ADDR) ||
                    (rd_addr == `PERIOD_ADDR) || (rd_addr == `IRQ_STATUS_ADDR) ||
                    (rd_addr == `IRQ_MASK_ADDR);
   // Read selection; registers readable at any moment
   assign rd_value =
      (rd_addr == `CONTROL_ADDR)    ? {run_reg, polarity_reg, 1'b0, cycle_flag_reg, rate_reg} :
      (rd_addr == `DUTY_ADDR)       ? duty_reg :
      (rd_addr == `PERIOD_ADDR)     ? period_reg :
      (rd_addr == `IRQ_STATUS_ADDR) ? {7'h00, irq_status_reg} :
      (rd_addr == `IRQ_MASK_ADDR)   ? {7'h00, irq_mask_reg} : 8'h00;

   // One read at a time
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

   // Read answer one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // No data pending
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         // Address taken
         rvalid_reg <= 1'b1;
         rdata_reg  <= {24'h000000, rd_value};
         rresp_reg  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
         // Data taken
         rvalid_reg <= 1'b0;
      end
   end

   // -----------------------------------------------------------------------------
   // Generator timing
   // -----------------------------------------------------------------------------
   logic tick;        // Modulator clock enable
   logic start;       // Run bit rising
   logic wrap;        // Frame completes
   logic reload;      // Settings move to active copies

   wire run_set = wr_byte && wr_ctrl && w_data_reg[`RUN_BIT];
   // A start is a write setting the run bit while halted
   assign start  = run_set && !run_reg;
   // Frame ends after period plus one ticks
   assign wrap   = run_reg && tick && (count_reg == act_period_reg);
   // Reload at start or at wrap
   assign reload = start || wrap;

   // Prescaler; stops ticking with the system clock in stop
   // Cleared while halted, so a start is clean
   rate_prescaler prescaler (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .run       (run_reg),
      .rate_code (rate_reg),
      .tick      (tick)
   );

   // -----------------------------------------------------------------------------
   // Control register and programmed values
   // -----------------------------------------------------------------------------
   // Reset clears run, rate, polarity and duty
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // Channel off, pin high
         run_reg        <= 1'b0;
         polarity_reg   <= 1'b0;
         rate_reg       <= 4'h0;
         duty_reg       <= `DUTY_RESET;
         period_reg     <= `PERIOD_RESET;
         shadow_pol_reg <= 1'b0;
         irq_mask_reg   <= `MASK_RESET;
      end else begin
         // Control word
         if (wr_byte && wr_ctrl) begin
            run_reg      <= w_data_reg[`RUN_BIT];
            polarity_reg <= w_data_reg[`POLARITY_BIT];
            rate_reg     <= w_data_reg[`RATE_MSB:`RATE_LSB];
         end

         // Duty; shadows polarity
         if (wr_byte && wr_duty) begin
            duty_reg       <= w_data_reg;
            shadow_pol_reg <= polarity_reg;
         end

         // Period
         if (wr_byte && wr_period) begin
            period_reg <= w_data_reg;
         end

         // Interrupt mask
         if (wr_byte && wr_mask) begin
            irq_mask_reg <= w_data_reg[0];
         end
      end
   end

   // Cycle flag and interrupt status: set wins over clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cycle_flag_reg <= 1'b0;
         irq_status_reg <= 1'b0;
      end else begin
         // Frame-end flag
         if (wrap) begin
            cycle_flag_reg <= 1'b1;
         end else if (wr_byte && wr_ctrl && w_data_reg[`CYCLE_BIT]) begin
            cycle_flag_reg <= 1'b0;
         end

         // Sticky interrupt status
         if (wrap) begin
            irq_status_reg <= 1'b1;
         end else if (wr_byte && wr_stat && w_data_reg[0]) begin
            irq_status_reg <= 1'b0;
         end
      end
   end

   assign irq = irq_status_reg && irq_mask_reg;

   // -----------------------------------------------------------------------------
   // Active copies and frame counter
   // -----------------------------------------------------------------------------
   // Pending values taken at start or wrap
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // Same as the programmed values
         act_duty_reg   <= `DUTY_RESET;
         act_period_reg <= `PERIOD_RESET;
         act_pol_reg    <= 1'b0;
      end else if (reload) begin
         // A write on this edge wins
         act_duty_reg   <= (wr_byte && wr_duty) ? w_data_reg : duty_reg;
         act_period_reg <= (wr_byte && wr_period) ? w_data_reg : period_reg;
         act_pol_reg    <= (wr_byte && wr_duty) ? polarity_reg : shadow_pol_reg;
      end
   end

   // Counter runs 0..period; cleared to zero while halted
   always_ff @(posedge aclk) begin
      if (!aresetn || !run_reg || start) begin
         // Halted or starting
         count_reg <= 8'h00;
      end else if (wrap) begin
         // Next frame
         count_reg <= 8'h00;
      end else if (tick) begin
         // One modulator clock
         count_reg <= count_reg + 8'h01;
      end
   end

   // -----------------------------------------------------------------------------
   // Output stage
   // -----------------------------------------------------------------------------
   logic active;     // Active phase of the frame
   logic out_next;   // Output next value
   logic zero_duty;  // Duty of zero in use

   // Active while count below duty; duty above period is passive
   assign active    = (act_duty_reg <= act_period_reg) && (count_reg < act_duty_reg);
   // Polarity one with zero duty stays on
   assign zero_duty = (act_duty_reg == 8'h00);
   // Active level follows polarity; halted output idles high
   assign out_next  = !run_reg ? 1'b1 : (act_pol_reg ? (active || zero_duty) : !active);

   // Registered output pin
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // Idle level
         out_reg <= 1'b1;
      end else begin
         // One cycle behind the frame
         out_reg <= out_next;
      end
   end

   assign pwm_out = out_reg;

endmodule

/* design/pulse_modulator_pkg.sv */
// Types shared by the pulse modulator files.
// Assumes the header of constants is included where offsets are needed.
package pulse_modulator_pkg;

   // Rate code selecting the modulator clock divider
   typedef logic [3:0] rate_code_type;

   // Eight-bit register value
   typedef logic [7:0] byte_type;

endpackage

/* design/pulse_modulator_regs.svh */
// Register offsets, field positions, reset values and AXI response codes for the pulse modulator.
// Assumes byte addressing on a 32-bit AXI4-Lite bus; each register takes one aligned word.
`ifndef PULSE_MODULATOR_REGS_SVH
`define PULSE_MODULATOR_REGS_SVH

// -----------------------------------------------------------------------------
// Register indices and byte addresses
// -----------------------------------------------------------------------------
`define CONTROL_INDEX      8'h2D
`define DUTY_INDEX         8'h2E
`define PERIOD_INDEX       8'h2F
`define IRQ_STATUS_INDEX   8'h30
`define IRQ_MASK_INDEX     8'h31
`define CONTROL_ADDR       {`CONTROL_INDEX, 2'b00}
`define DUTY_ADDR          {`DUTY_INDEX, 2'b00}
`define PERIOD_ADDR        {`PERIOD_INDEX, 2'b00}
`define IRQ_STATUS_ADDR    {`IRQ_STATUS_INDEX, 2'b00}
`define IRQ_MASK_ADDR      {`IRQ_MASK_INDEX, 2'b00}

// -----------------------------------------------------------------------------
// Control word fields
// -----------------------------------------------------------------------------
`define RUN_BIT            7
`define POLARITY_BIT       6
`define CYCLE_BIT          4
`define RATE_MSB           3
`define RATE_LSB           0

// -----------------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------------
`define CONTROL_RESET      8'h00
`define DUTY_RESET         8'h00
`define PERIOD_RESET       8'hFF
`define MASK_RESET         1'b0

// -----------------------------------------------------------------------------
// AXI responses
// -----------------------------------------------------------------------------
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10

`endif

/* design/rate_prescaler.sv */
// Prescaler producing one-cycle modulator clock enables from the system clock.
// Assumes the rate code comes straight from the control register, unbuffered.
`timescale 1ns/1ps

module rate_prescaler
   import pulse_modulator_pkg::*;
(
   input  wire logic          aclk,       // System clock
   input  wire logic          aresetn,    // Synchronous reset, active low
   input  wire logic          run,        // Counts only while running
   input  wire rate_code_type rate_code,  // Divider select
   output logic               tick        // Modulator clock enable
);

   // -----------------------------------------------------------------------------
   // Divider counting in half-steps
   // -----------------------------------------------------------------------------
   // Each oscillator clock adds two half-steps; divide by N means 2N
   // half-steps. Fractional rates alternate gaps, giving the right average.
   logic [8:0] acc_reg;   // Accumulated half-steps
   logic [8:0] acc_next;  // Next accumulator
   logic [8:0] limit;     // Half-steps per enable

   // Twice the divider ratio for each rate code
   function automatic logic [8:0] twice_ratio(input rate_code_type code);
      logic [8:0] base;
      base = 9'h002 << code[3:1];
      if (code[0]) begin
         twice_ratio = base + (base >> 1);
      end else begin
         twice_ratio = base;
      end
   endfunction

   // Ratio table follows 1,1.5,2,3,...,128,192
   assign limit    = twice_ratio(rate_code);
   assign acc_next = acc_reg + 9'h002;
   // Rate changes act at once, no buffering
   assign tick     = run && (acc_next >= limit);

   // Accumulator; cleared when halted so a start begins fresh
   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         acc_reg <= 9'h000;
      end else if (tick) begin
         acc_reg <= acc_next - limit;
      end else begin
         acc_reg <= acc_next;
      end
   end

endmodule

/* tb/pulse_load_model.sv */
// External load on the modulated pin; counts high cycles in a window.
// Assumes the bench opens the window with meas, one clock domain.
`timescale 1ns/1ps

module pulse_load_model (
   input  wire logic        aclk,        // System clock
   input  wire logic        pwm_out,     // Pin driving the load
   input  wire logic        meas,        // Measurement window
   output logic [31:0]      high_count   // High cycles seen
);
   // Clear outside the window, count high samples inside
   always_ff @(posedge aclk) begin
      if (!meas) begin
         high_count <= 32'h0;
      end else if (pwm_out) begin
         high_count <= high_count + 32'h1;
      end
   end
endmodule

/* tb/pulse_modulator_assertions.sv */
// Checker for bus handshakes and reset state of the pulse modulator.
// Assumes it is bound to the pulse_modulator ports.
`timescale 1ns/1ps

module pulse_modulator_assertions (
   input wire logic        aclk,           // System clock
   input wire logic        aresetn,        // Reset, active low
   input wire logic        s_axi_awvalid,  // Write address valid
   input wire logic        s_axi_awready,  // Write address ready
   input wire logic        s_axi_wvalid,   // Write data valid
   input wire logic        s_axi_wready,   // Write data ready
   input wire logic        s_axi_bvalid,   // Write response valid
   input wire logic        s_axi_bready,   // Write response ready
   input wire logic        s_axi_arvalid,  // Read address valid
   input wire logic        s_axi_arready,  // Read address ready
   input wire logic [31:0] s_axi_rdata,    // Read data
   input wire logic        s_axi_rvalid,   // Read data valid
   input wire logic        s_axi_rready,   // Read data ready
   input wire logic        pwm_out,        // Modulated pin
   input wire logic        irq             // Interrupt
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ----------------------------
   // Handshake relations
   // ----------------------------
   AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write channels open during response");
   AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address open during read data");
   AST_READ_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   AST_WRITE_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write response timing wrong");
   AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not released");
   AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data not released");
   AST_RDATA_HIGH: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   AST_RESET_OUT: assert property (disable iff (1'h0)
      !aresetn |=> pwm_out && !irq && !s_axi_bvalid && !s_axi_rvalid)
      else $error("reset state wrong");

   // ----------------------------
   // Scenario coverage
   // ----------------------------
   COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
   COV_READ: cover property (s_axi_rvalid && s_axi_rready);
   COV_IRQ: cover property ($rose(irq));
   COV_PULSE: cover property ($fell(pwm_out));
endmodule

bind pulse_modulator pulse_modulator_assertions chk_u (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .pwm_out, .irq
);

/* tb/single_channel_pulse_modulator_tb.sv */
// Bench driving pulse_modulator over AXI4-Lite and measuring the pin.
// Assumes the load model and bound checker are compiled alongside.
`timescale 1ns/1ps
`include "pulse_modulator_regs.svh"

module single_channel_pulse_modulator_tb
   import pulse_modulator_pkg::*;
;
   logic        aclk, aresetn, meas;                             // Clock, reset, window
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr;         // Bus payloads
   logic [3:0]  s_axi_wstrb;                                     // Strobes
   logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;       // Write controls
   logic        s_axi_arvalid, s_axi_rready;                     // Read controls
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;       // Write answers
   logic        s_axi_arready, s_axi_rvalid, pwm_out, irq;       // Read answers, pins
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;                   // Responses
   logic [31:0] s_axi_rdata, rd_val, high_count;                 // Data seen
   int          n_errors, n_tests, cycles;                       // Counters
   localparam logic [31:0] A_CTRL = {22'h0, `CONTROL_ADDR};
   localparam logic [31:0] A_DUTY = {22'h0, `DUTY_ADDR};
   localparam logic [31:0] A_PER  = {22'h0, `PERIOD_ADDR};
   localparam logic [31:0] A_STAT = {22'h0, `IRQ_STATUS_ADDR};
   localparam logic [31:0] A_MASK = {22'h0, `IRQ_MASK_ADDR};
   localparam int          DH[16] = '{2, 3, 4, 6, 8, 12, 16, 24, 32, 48, 64, 96, 128, 192, 256, 384};

   pulse_modulator dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .pwm_out, .irq);
   pulse_load_model load_u (.aclk, .pwm_out, .meas, .high_count);

   // ----------------------------
   // Clock and hang guard
   // ----------------------------
   initial begin
      aclk = 1'h0;
      forever #4 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_errors++;
         end_of_test();
      end
   end

   // ----------------------------
   // Comparison and closing
   // ----------------------------
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task end_of_test;
      $display("n_errors %0d n_tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ----------------------------
   // Bus master tasks
   // ----------------------------
   task wr(input logic [31:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'h0;
      w_ok = 1'h0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ok = 1'h1;
            s_axi_awvalid <= 1'h0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ok = 1'h1;
            s_axi_wvalid <= 1'h0;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'h0;
      @(posedge aclk);
   endtask
   task rd(input string nm, input logic [31:0] a, input logic [31:0] exp);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge aclk); while (!s_axi_rvalid);
      rd_val = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'h0;
      @(posedge aclk);
      chk(nm, rd_val, exp);
   endtask

   // ----------------------------
   // Waveform tasks
   // ----------------------------
   task meas_hi(input string nm, input int n, input logic [31:0] exp);
      meas <= 1'h1;
      repeat (n) @(posedge aclk);
      meas <= 1'h0;
      @(negedge aclk);
      chk(nm, high_count, exp);
      @(posedge aclk);
   endtask
   task wave(input logic [7:0] p, d, input logic polarity_bit, input logic [3:0] rt, input int fr,
             input logic [31:0] exp);
      wr(A_CTRL, {24'h0, 1'h0, polarity_bit, 2'h0, rt});
      wr(A_PER, {24'h0, p});
      wr(A_DUTY, {24'h0, d});
      wr(A_CTRL, {24'h0, 1'h1, polarity_bit, 2'h0, rt});
      repeat (2 * fr) @(posedge aclk);
      meas_hi("high cycles", 2 * fr, exp);
   endtask

   // ----------------------------
   // Main sequence
   // ----------------------------
   initial begin
      {aresetn, meas, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      s_axi_wstrb = 4'hF;
      {n_errors, n_tests, cycles} = 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      chk("pin after reset", {31'h0, pwm_out}, 32'h1);
      rd("control reset", A_CTRL, 32'h0);
      rd("duty reset", A_DUTY, 32'h0);
      rd("period reset", A_PER, 32'hFF);
      rd("mask reset", A_MASK, 32'h0);
      rd("unmapped read", 32'h0, 32'h0);
      chk("unmapped read resp", {30'h0, rsp}, {30'h0, `RESP_SLVERR});
      wr(32'h0, 32'hFF);
      chk("unmapped write resp", {30'h0, rsp}, {30'h0, `RESP_SLVERR});
      wave(8'h07, 8'h03, 1'h1, 4'h0, 8, 32'h6);
      wave(8'h07, 8'h03, 1'h0, 4'h0, 8, 32'hA);
      wave(8'h07, 8'h00, 1'h0, 4'h0, 8, 32'h10);
      wave(8'h07, 8'h00, 1'h1, 4'h0, 8, 32'h10);
      wave(8'h03, 8'h05, 1'h0, 4'h0, 4, 32'h8);
      wave(8'hFF, 8'hFF, 1'h1, 4'h0, 256, 32'h1FE);
      for (int k = 0; k < 16; k++) begin
         wave(8'h03, 8'h02, 1'h1, 4'(k), 2 * DH[k], 32'(2 * DH[k]));
      end
      wave(8'h07, 8'h03, 1'h1, 4'h0, 8, 32'h6);
      wr(A_CTRL, 32'h80);
      repeat (16) @(posedge aclk);
      meas_hi("polarity not shadowed", 16, 32'h6);
      wr(A_DUTY, 32'h06);
      repeat (16) @(posedge aclk);
      meas_hi("new duty and polarity", 16, 32'h4);
      rd("duty readback", A_DUTY, 32'h06);
      rd("cycle flag set", A_CTRL, 32'h90);
      rd("irq status set", A_STAT, 32'h1);
      chk("irq masked", {31'h0, irq}, 32'h0);
      wr(A_MASK, 32'h1);
      chk("irq unmasked", {31'h0, irq}, 32'h1);
      wr(A_CTRL, 32'h10);
      wr(A_CTRL, 32'h10);
      rd("cycle flag cleared", A_CTRL, 32'h0);
      wr(A_STAT, 32'h1);
      rd("irq status cleared", A_STAT, 32'h0);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      meas_hi("halted pin high", 16, 32'h10);
      end_of_test();
   end
endmodule
